/* rtl/uartfc_fifo.sv */
// Character buffer that shrinks to one entry in character mode
`timescale 1ns/1ps
module uartfc_fifo (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode
    input wire logic flush,
    input wire logic one_deep,
    // Fill side
    input wire logic push,
    input wire logic [7:0] wdata,
    // Drain side
    input wire logic pop,
    output logic [7:0] rdata,
    // Levels
    output logic full,
    output logic empty,
    output logic [4:0] level
);

    uartfc_pkg::uartfc_fifo_st_t st;
    uartfc_pkg::uartfc_fifo_st_t next_st;
    logic [4:0] limit;
    logic do_push;
    logic do_pop;

    // Depth limit follows the buffering mode
    assign limit = one_deep ? uartfc_pkg::CHAR_LEVEL : uartfc_pkg::FIFO_LEVEL_MAX;
    assign full = st.level >= limit;
    assign empty = st.level == '0;
    assign level = st.level;
    assign rdata = st.mem[st.rptr];

    // Pointer and level update; a flush drops every held character
    always_comb begin
        next_st = st;
        do_push = push && !full;
        do_pop = pop && !empty;
        if (flush) begin
            next_st.wptr = '0;
            next_st.rptr = '0;
            next_st.level = '0;
        end else begin
            if (do_push) begin
                next_st.mem[st.wptr] = wdata;
                next_st.wptr = 4'(st.wptr + 4'h1);
            end
            if (do_pop) begin
                next_st.rptr = 4'(st.rptr + 4'h1);
            end
            next_st.level = 5'(st.level + {4'h0, do_push} - {4'h0, do_pop});
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    char_depth_a: assert property (one_deep && $past(one_deep) |-> st.level <= 5'h01)
        else $error("character mode holds more than one byte");
    fifo_depth_a: assert property (!one_deep && st.level == 5'h0F && push && !pop && !flush
        |=> full && st.level == 5'h10)
        else $error("buffer did not fill to sixteen entries");

endmodule : uartfc_fifo

/* rtl/uartfc_pkg.sv */
// Shared constants and types for the serial line framing controller
package uartfc_pkg;

    // ------------------------------------------------------------
    // Register map and bus
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_LINE = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [4:0] LINE_RESET = 5'h00;
    localparam int LINE_FEN_POS = 4;

    // Status register bit positions
    localparam int ST_TX_FULL = 0;
    localparam int ST_RX_EMPTY = 1;
    localparam int ST_TX_BUSY = 2;
    localparam int ST_PAR_ERR = 3;
    localparam int ST_FRM_ERR = 4;
    localparam int ST_BREAK = 5;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } uartfc_bus_t;

    // Field order matches bits 4 down to 0 of line_control
    typedef struct packed {
        logic fifo_enable;
        logic two_stop_select;
        logic even_parity_select;
        logic parity_enable;
        logic send_break;
    } uartfc_line_t;

    // ------------------------------------------------------------
    // Buffering and bit timing
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_LEVEL_MAX = 5'h10;
    localparam logic [4:0] CHAR_LEVEL = 5'h01;
    localparam logic [15:0] BIT_CYCLES = 16'h0364;
    localparam logic [15:0] HALF_BIT = 16'h01B2;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [1:0] RX_IDLE_SYNC = 2'h3;

    // ------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_START = 6'h02,
        TX_DATA = 6'h04,
        TX_PARITY = 6'h08,
        TX_STOP = 6'h10,
        TX_BREAK = 6'h20
    } uartfc_tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PARITY = 5'h08,
        RX_STOP = 5'h10
    } uartfc_rx_state_t;

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][7:0] mem;
        logic [3:0] wptr;
        logic [3:0] rptr;
        logic [4:0] level;
    } uartfc_fifo_st_t;

    typedef struct packed {
        uartfc_line_t line;
        logic [31:0] rdata;
        uartfc_tx_state_t tx_state;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [7:0] tx_byte;
        logic [7:0] tx_shift;
        logic fr_two_stop;
        logic fr_parity;
        logic fr_even;
        logic tx_line;
        logic [1:0] rx_sync;
        uartfc_rx_state_t rx_state;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_shift;
        logic rx_parity;
        logic rx_even;
        logic rx_pbad;
        logic par_err;
        logic frame_err;
    } uartfc_main_t;

    localparam uartfc_main_t MAIN_RESET = '{
        tx_state: TX_IDLE,
        rx_state: RX_IDLE,
        tx_line: 1'b1,
        rx_sync: RX_IDLE_SYNC,
        default: '0
    };

endpackage : uartfc_pkg

/* rtl/uartfc_top.sv */
// Serial line framing: line control register, transmitter and receiver
`timescale 1ns/1ps

// What this block does
// - Buffering enabled: multi-entry transmit and receive buffers
// - Buffering disabled: one-byte holding registers
// - Two-stop select set: two stop bits
// - Even select chooses even, else odd parity
// - Even select ignored while parity is off
// - Parity enable adds and checks parity bit
// - Break: finish character, then hold line low
module uartfc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire uartfc_pkg::uartfc_bus_t bus_req,
    output logic [31:0] bus_rdata,
    // Serial line
    input wire logic serial_rx_in,
    output logic serial_tx_out
);

    uartfc_pkg::uartfc_main_t st;
    uartfc_pkg::uartfc_main_t next_st;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic flush;
    logic tx_full;
    logic tx_empty;
    logic rx_empty;
    logic [7:0] tx_head;
    logic [7:0] rx_head;
    logic rx_in;
    logic cnt_done;
    logic rx_tick;
    logic [31:0] status;

    // ------------------------------------------------------------
    // Buffers
    // ------------------------------------------------------------
    uartfc_fifo u_tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(flush),
        .one_deep(!st.line.fifo_enable),
        .push(tx_push),
        .wdata(bus_req.wdata[7:0]),
        .pop(tx_pop),
        .rdata(tx_head),
        .full(tx_full),
        .empty(tx_empty),
        .level()
    );

    uartfc_fifo u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(flush),
        .one_deep(!st.line.fifo_enable),
        .push(rx_push),
        .wdata(st.rx_shift),
        .pop(rx_pop),
        .rdata(rx_head),
        .full(),
        .empty(rx_empty),
        .level()
    );

    // Only the second synchroniser stage is looked at
    assign rx_in = st.rx_sync[1];
    assign cnt_done = st.tx_cnt == '0;
    assign rx_tick = st.rx_cnt == '0;

    // Status word, built from live state
    always_comb begin
        status = '0;
        status[uartfc_pkg::ST_TX_FULL] = tx_full;
        status[uartfc_pkg::ST_RX_EMPTY] = rx_empty;
        status[uartfc_pkg::ST_TX_BUSY] = st.tx_state != uartfc_pkg::TX_IDLE;
        status[uartfc_pkg::ST_PAR_ERR] = st.par_err;
        status[uartfc_pkg::ST_FRM_ERR] = st.frame_err;
        status[uartfc_pkg::ST_BREAK] = st.tx_state == uartfc_pkg::TX_BREAK;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        rx_push = 1'b0;
        tx_pop = 1'b0;
        // Register port; changing the buffering mode empties both buffers
        flush = bus_req.wr && bus_req.addr == uartfc_pkg::OFF_LINE
            && bus_req.wdata[uartfc_pkg::LINE_FEN_POS] != st.line.fifo_enable;
        tx_push = bus_req.wr && bus_req.addr == uartfc_pkg::OFF_DATA;
        rx_pop = bus_req.rd && bus_req.addr == uartfc_pkg::OFF_DATA;
        if (bus_req.wr && bus_req.addr == uartfc_pkg::OFF_LINE) begin
            next_st.line = uartfc_pkg::uartfc_line_t'(bus_req.wdata[4:0]);
        end
        next_st.rdata = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                uartfc_pkg::OFF_LINE: next_st.rdata = {27'h0, st.line};
                uartfc_pkg::OFF_DATA: next_st.rdata = {24'h0, rx_empty ? 8'h00 : rx_head};
                uartfc_pkg::OFF_STAT: next_st.rdata = status;
                default: next_st.rdata = '0;
            endcase
        end

        // Transmitter; each bit of a frame lasts one bit time
        next_st.tx_cnt = cnt_done ? '0 : 16'(st.tx_cnt - 16'h1);
        case (st.tx_state)
            uartfc_pkg::TX_IDLE: begin
                // Break is only taken between characters
                if (st.line.send_break) begin
                    next_st.tx_state = uartfc_pkg::TX_BREAK;
                end else if (!tx_empty) begin
                    tx_pop = 1'b1;
                    next_st.tx_byte = tx_head;
                    next_st.tx_shift = tx_head;
                    next_st.fr_two_stop = st.line.two_stop_select;
                    next_st.fr_parity = st.line.parity_enable;
                    next_st.fr_even = st.line.even_parity_select;
                    next_st.tx_cnt = 16'(uartfc_pkg::BIT_CYCLES - 16'h1);
                    next_st.tx_state = uartfc_pkg::TX_START;
                end
            end
            uartfc_pkg::TX_START: if (cnt_done) begin
                next_st.tx_bit = '0;
                next_st.tx_cnt = 16'(uartfc_pkg::BIT_CYCLES - 16'h1);
                next_st.tx_state = uartfc_pkg::TX_DATA;
            end
            uartfc_pkg::TX_DATA: if (cnt_done) begin
                next_st.tx_cnt = 16'(uartfc_pkg::BIT_CYCLES - 16'h1);
                next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
                next_st.tx_bit = 4'(st.tx_bit + 4'h1);
                if (st.tx_bit == uartfc_pkg::LAST_DATA_BIT) begin
                    next_st.tx_bit = {3'h0, st.fr_two_stop};
                    next_st.tx_state = st.fr_parity ? uartfc_pkg::TX_PARITY
                        : uartfc_pkg::TX_STOP;
                end
            end
            uartfc_pkg::TX_PARITY: if (cnt_done) begin
                next_st.tx_cnt = 16'(uartfc_pkg::BIT_CYCLES - 16'h1);
                next_st.tx_state = uartfc_pkg::TX_STOP;
            end
            uartfc_pkg::TX_STOP: if (cnt_done) begin
                next_st.tx_cnt = 16'(uartfc_pkg::BIT_CYCLES - 16'h1);
                next_st.tx_bit = 4'(st.tx_bit - 4'h1);
                if (st.tx_bit == '0) begin
                    next_st.tx_state = uartfc_pkg::TX_IDLE;
                end
            end
            uartfc_pkg::TX_BREAK: if (!st.line.send_break) begin
                next_st.tx_state = uartfc_pkg::TX_IDLE;
            end
            default: next_st.tx_state = uartfc_pkg::TX_IDLE;
        endcase

        // Line level follows the next state so the pin is a plain flop
        case (next_st.tx_state)
            uartfc_pkg::TX_START: next_st.tx_line = 1'b0;
            uartfc_pkg::TX_DATA: next_st.tx_line = next_st.tx_shift[0];
            uartfc_pkg::TX_PARITY: next_st.tx_line = ^next_st.tx_byte ^ ~next_st.fr_even;
            uartfc_pkg::TX_BREAK: next_st.tx_line = 1'b0;
            default: next_st.tx_line = 1'b1;
        endcase

        // Receiver samples each bit at its middle
        next_st.rx_sync = {st.rx_sync[0], serial_rx_in};
        next_st.rx_cnt = rx_tick ? '0 : 16'(st.rx_cnt - 16'h1);
        case (st.rx_state)
            uartfc_pkg::RX_IDLE: if (!rx_in) begin
                next_st.rx_cnt = uartfc_pkg::HALF_BIT;
                next_st.rx_state = uartfc_pkg::RX_START;
            end
            uartfc_pkg::RX_START: if (rx_tick) begin
                // A glitch shorter than half a bit is not a start bit
                next_st.rx_state = rx_in ? uartfc_pkg::RX_IDLE : uartfc_pkg::RX_DATA;
                next_st.rx_cnt = 16'(uartfc_pkg::BIT_CYCLES - 16'h1);
                next_st.rx_bit = '0;
                next_st.rx_parity = st.line.parity_enable;
                next_st.rx_even = st.line.even_parity_select;
            end
            uartfc_pkg::RX_DATA: if (rx_tick) begin
                next_st.rx_cnt = 16'(uartfc_pkg::BIT_CYCLES - 16'h1);
                next_st.rx_shift = {rx_in, st.rx_shift[7:1]};
                next_st.rx_bit = 4'(st.rx_bit + 4'h1);
                next_st.rx_pbad = 1'b0;
                if (st.rx_bit == uartfc_pkg::LAST_DATA_BIT) begin
                    next_st.rx_state = st.rx_parity ? uartfc_pkg::RX_PARITY
                        : uartfc_pkg::RX_STOP;
                end
            end
            uartfc_pkg::RX_PARITY: if (rx_tick) begin
                next_st.rx_cnt = 16'(uartfc_pkg::BIT_CYCLES - 16'h1);
                next_st.rx_pbad = ^{st.rx_shift, rx_in} ^ ~st.rx_even;
                next_st.rx_state = uartfc_pkg::RX_STOP;
            end
            uartfc_pkg::RX_STOP: if (rx_tick) begin
                // Dropped when the buffer is full; no overrun flag kept
                rx_push = 1'b1;
                next_st.rx_state = uartfc_pkg::RX_IDLE;
            end
            default: next_st.rx_state = uartfc_pkg::RX_IDLE;
        endcase

        // Error flags: write one to clear, a new error wins over the clear
        if (bus_req.wr && bus_req.addr == uartfc_pkg::OFF_STAT) begin
            next_st.par_err = st.par_err & ~bus_req.wdata[uartfc_pkg::ST_PAR_ERR];
            next_st.frame_err = st.frame_err & ~bus_req.wdata[uartfc_pkg::ST_FRM_ERR];
        end
        if (rx_push) begin
            next_st.par_err = next_st.par_err | st.rx_pbad;
            next_st.frame_err = next_st.frame_err | !rx_in;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= uartfc_pkg::MAIN_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign bus_rdata = st.rdata;
    assign serial_tx_out = st.tx_line;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_data_end;
        st.tx_state == uartfc_pkg::TX_DATA && st.tx_bit == uartfc_pkg::LAST_DATA_BIT
            && st.tx_cnt == '0;
    endsequence
    sequence s_stop_start;
        $rose(st.tx_state == uartfc_pkg::TX_STOP);
    endsequence

    parity_slot_a: assert property (s_data_end |=> (st.tx_state == uartfc_pkg::TX_PARITY)
        == st.fr_parity)
        else $error("parity slot does not follow parity enable");
    parity_value_a: assert property (st.tx_state == uartfc_pkg::TX_PARITY
        |-> st.tx_line == (^st.tx_byte ^ ~st.fr_even))
        else $error("wrong parity bit sent");
    parity_order_a: assert property ($rose(st.tx_state == uartfc_pkg::TX_PARITY)
        |-> $past(st.tx_state) == uartfc_pkg::TX_DATA)
        else $error("parity bit not right after data");
    stop_level_a: assert property (st.tx_state == uartfc_pkg::TX_STOP |-> st.tx_line)
        else $error("stop bit not high");
    stop_count_a: assert property (s_stop_start |-> st.tx_bit == {3'h0, st.fr_two_stop})
        else $error("stop bit count wrong");
    break_low_a: assert property (st.tx_state == uartfc_pkg::TX_BREAK |-> !st.tx_line)
        else $error("break does not hold line low");
    break_defer_a: assert property ($rose(st.tx_state == uartfc_pkg::TX_BREAK)
        |-> $past(st.tx_state) == uartfc_pkg::TX_IDLE)
        else $error("break cut a character short");
    break_end_a: assert property (st.tx_state == uartfc_pkg::TX_BREAK && !st.line.send_break
        |=> st.tx_state == uartfc_pkg::TX_IDLE && st.tx_line)
        else $error("line not released after break");
    rx_parity_off_a: assert property ($rose(st.par_err) |-> st.rx_parity)
        else $error("parity error flagged with parity off");

endmodule : uartfc_top

/* sim/tb.sv */
// Self-checking bench for the serial line framing controller
`timescale 1ns/1ps
module tb;
    localparam int BIT = int'(uartfc_pkg::BIT_CYCLES);
    localparam int TIMEOUT = 100000;
    localparam logic [7:0] LINE = uartfc_pkg::OFF_LINE;
    localparam logic [7:0] DATA = uartfc_pkg::OFF_DATA;
    localparam logic [7:0] STAT = uartfc_pkg::OFF_STAT;
    typedef struct packed {
        logic [4:0] line;
        logic [7:0] data;
        logic last_bit;
        logic [3:0] nbits;
    } uartfc_row_t;
    // Transmit cases: line setting, byte, bit after the data, bits per frame
    localparam uartfc_row_t ROWS [4] = '{
        '{5'h04, 8'hA5, 1'b1, 4'hA},
        '{5'h0A, 8'h01, 1'b0, 4'hC},
        '{5'h02, 8'h3C, 1'b1, 4'hB},
        '{5'h06, 8'h3C, 1'b0, 4'hB}
    };

    logic clk;
    logic rst_n;
    uartfc_pkg::uartfc_bus_t bus_req;
    logic [31:0] bus_rdata;
    logic serial_rx_in;
    logic serial_tx_out;
    int failures;
    int tests_run;
    int cycles;
    int k;
    int span;
    int prev_bits;
    int highs;
    logic [31:0] d;

    uartfc_top dut (
        .clk(clk),
        .rst_n(rst_n),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .serial_rx_in(serial_rx_in),
        .serial_tx_out(serial_tx_out)
    );

    uartfc_remote #(.BIT(BIT)) remote (
        .clk(clk),
        .tx_line(serial_tx_out),
        .rx_line(serial_rx_in)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic final_report();
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Strobe held across one edge, then a quiet cycle
    task automatic bus_write(input logic [7:0] a, input logic [31:0] w);
        bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        @(posedge clk);
    endtask : bus_write

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
        @(posedge clk);
        check(d, exp);
    endtask : rd_chk

    task automatic wait_frame(input int n);
        k = 0;
        while (remote.frames < n && k < 20000) begin
            @(posedge clk);
            k++;
        end
        check(remote.frames >= n, 1);
    endtask : wait_frame

    task automatic wait_tx(input logic lvl, input int lim);
        k = 0;
        while (serial_tx_out !== lvl && k < lim) begin
            @(posedge clk);
            #1 k++;
        end
        check(k < lim, 1);
    endtask : wait_tx

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            failures++;
            final_report();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        bus_req = '0;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        // Reset sampled low at eight rising edges
        repeat (7) @(posedge clk);
        #1 check(serial_tx_out, 1);
        check(bus_rdata, 0);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(LINE, 32'h0);
        rd_chk(STAT, 32'h2);
        bus_write(8'h0C, 32'hFFFFFFFF);
        rd_chk(8'h0C, 32'h0);
        // Deep buffer: one byte leaves for the wire, sixteen fill it
        bus_write(LINE, 32'h10);
        for (int i = 0; i < 17; i++) bus_write(DATA, i);
        rd_chk(STAT, 32'h7);
        bus_write(LINE, 32'h0);
        rd_chk(STAT, 32'h6);
        bus_write(DATA, 32'h11);
        rd_chk(STAT, 32'h7);
        bus_write(LINE, 32'h10);
        bus_write(LINE, 32'h0);
        rd_chk(STAT, 32'h6);
        wait_frame(1);
        // Frames back to back; spacing of starts gives the frame length
        prev_bits = 10;
        for (int r = 0; r < 4; r++) begin
            bus_write(LINE, {27'h7FFFFFF, ROWS[r].line});
            rd_chk(LINE, {27'h0, ROWS[r].line});
            bus_write(DATA, {24'h0, ROWS[r].data});
            wait_frame(r + 2);
            check(remote.samples, {ROWS[r].last_bit, ROWS[r].data, 1'b0});
            span = remote.period - prev_bits * BIT;
            check(span >= -2 && span <= 4, 1);
            prev_bits = int'(ROWS[r].nbits);
        end
        // Break requested mid-parity: one stop bit must still go out
        bus_write(LINE, 32'h1);
        wait_tx(1'b1, 1000);
        wait_tx(1'b0, 2000);
        check(k >= BIT - 2 && k <= BIT + 2, 1);
        // Held for two full frames before clearing
        highs = 0;
        repeat (2 * 11 * BIT) begin
            @(posedge clk);
            #1 if (serial_tx_out !== 1'b0) highs++;
        end
        check(highs, 0);
        @(posedge clk);
        // Break active, transmitter busy, nothing received yet
        rd_chk(STAT, 32'h26);
        bus_write(LINE, 32'h0);
        @(posedge clk);
        #1 check(serial_tx_out, 1);
        @(posedge clk);
        // Receive path under even parity: good frame, then a bad one
        bus_write(LINE, 32'h6);
        remote.send_frame({1'b1, 1'b0, 8'h96, 1'b0});
        rd_chk(STAT, 32'h0);
        rd_chk(DATA, 32'h96);
        remote.send_frame({1'b0, 1'b1, 8'h96, 1'b0});
        rd_chk(STAT, 32'h18);
        rd_chk(DATA, 32'h96);
        bus_write(STAT, 32'h18);
        rd_chk(STAT, 32'h2);
        final_report();
    end
endmodule : tb

/* sim/uartfc_remote.sv */
// Behavioural remote serial device on the far side of the serial lines
`timescale 1ns/1ps
module uartfc_remote #(
    parameter int BIT = 868
) (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic tx_line,
    output logic rx_line
);
    logic [9:0] samples;
    int frames;
    int period;
    int start_cyc;
    int cyc;

    // ----------------------------------------
    // Receiving what the block transmits
    // ----------------------------------------
    initial begin
        rx_line = 1'b1;
        frames = 0;
        period = 0;
        start_cyc = 0;
        cyc = 0;
    end

    // Free cycle count, used for start-to-start spacing
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // Mid-bit samples: start, eight data, then parity or first stop
    always begin
        @(negedge tx_line);
        period = cyc - start_cyc;
        start_cyc = cyc;
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            samples[i] = tx_line;
            if (i < 9) repeat (BIT) @(posedge clk);
        end
        frames++;
    end

    // ----------------------------------------
    // Sending toward the block
    // ----------------------------------------
    // Bits go LSB first; line rests high at mark after the frame
    task automatic send_frame(input logic [10:0] bits);
        for (int i = 0; i < 11; i++) begin
            rx_line <= bits[i];
            repeat (BIT) @(posedge clk);
        end
        rx_line <= 1'b1;
    endtask : send_frame
endmodule : uartfc_remote
